// ==== rtl/pvi_pkg.sv ====
// Package for the prioritized vector interrupt controller.
// Assumes a 32-bit APB register bus with byte addresses and one clock.
package pvi_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFF_PROT = 8'h00;
  localparam logic [7:0] OFF_BASE_LOW = 8'h04;
  localparam logic [7:0] OFF_BASE_HIGH = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h0c;
  localparam logic [7:0] OFF_ENABLE = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_ACCEPTED = 8'h18;
  localparam logic [7:0] OFF_LEVEL0 = 8'h20;

  // Protection key that opens the vector table base for writing.
  localparam logic [15:0] PROT_KEY = 16'h0096;

  // Vector table base after reset, split into its two writable bytes.
  localparam logic [7:0] BASE_MID_RST = 8'h80;
  localparam logic [7:0] BASE_TOP_RST = 8'h00;

  // Field positions inside a level register and the status register.
  localparam int LVL_EVEN_LSB = 0;
  localparam int LVL_ODD_LSB = 8;
  localparam int STAT_IRQ_BIT = 15;
  localparam int STAT_LVL_LSB = 8;
  localparam int STAT_VEC_LSB = 0;

  // Vector numbering of the maskable sources.
  localparam int FIRST_VECTOR = 4;
  localparam int TIMER0_VECTOR = 8;
  localparam int LAST_VECTOR = 19;
  localparam int MAX_VECTOR = 31;

  // Fetch address of a vector: table base plus four bytes per vector.
  function automatic logic [23:0] vec_fetch_addr(input logic [23:0] base,
                                                 input logic [4:0] vec);
    vec_fetch_addr = base + {17'h00000, vec, 2'b00};
  endfunction : vec_fetch_addr

endpackage : pvi_pkg

// ==== rtl/pvi_source_cell.sv ====
// One peripheral interrupt cause: its sticky flag, enable and request.
// Assumes cause and clear inputs are synchronous to core_clk.
`timescale 1ns/1ps
module pvi_source_cell (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cause,
  input wire logic periph_clr,
  input wire logic sw_clr,
  input wire logic en_we,
  input wire logic en_wdata,
  output logic flag,
  output logic enable,
  output logic request
);

  logic flag_r;
  logic en_r;

  // The cause sets the flag and wins over a clear in the same cycle.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      flag_r <= 1'b0;
    end else if (cause) begin
      flag_r <= 1'b1;
    end else if (periph_clr || sw_clr) begin
      flag_r <= 1'b0;
    end
  end

  // Enable bit written by software.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      en_r <= 1'b0;
    end else if (en_we) begin
      en_r <= en_wdata;
    end
  end

  // Level based request, so enabling a set flag requests at once.
  assign request = flag_r & en_r;
  assign flag = flag_r;
  assign enable = en_r;

endmodule : pvi_source_cell

// ==== rtl/pvi_interrupt_arbiter.sv ====
// Combinational arbiter picking the highest level, then lowest vector.
// Assumes source i carries vector FIRST_VEC + i.
`timescale 1ns/1ps
module pvi_interrupt_arbiter #(
  parameter int NUM_SRC = 16,
  parameter int FIRST_VEC = 4
) (
  input wire logic [NUM_SRC-1:0] req,
  input wire logic [3*NUM_SRC-1:0] levels,
  output logic any_req,
  output logic [2:0] win_level,
  output logic [4:0] win_vector
);

  // Scan upward; only a strictly higher level displaces the current
  // winner, so equal levels keep the lower vector number.
  always_comb begin
    any_req = 1'b0;
    win_level = 3'h0;
    win_vector = 5'h00;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (req[i] && (!any_req || levels[3*i +: 3] > win_level)) begin
        any_req = 1'b1;
        win_level = levels[3*i +: 3];
        win_vector = 5'(FIRST_VEC + i);
      end
    end
  end

endmodule : pvi_interrupt_arbiter

// ==== rtl/pvi_ctrl.sv ====
// Prioritized vector interrupt controller top with its APB registers.
// Assumes an APB master on core_clk and peripherals giving cause pulses
// and their own clear strobes synchronous to the same clock.
//
// Behaviour
// - Sources have fixed vectors, timer 8 to 19.
// - Fetch address is base plus four times vector.
// - Base reads 0x8000 after reset.
// - Low eight base bits are always zero.
// - Base writable only after key 0x0096.
// - Each cause sets its own flag.
// - Request only when flag and enable set.
// - Enabling a set flag requests at once.
// - Present request, winning level and vector.
// - Levels are three bits, reset to zero.
// - Highest level wins, ties to lowest vector.
// - Losers stay pending until served.
// - Higher newcomer replaces the presented request.
// - Clearing a flag withdraws its request.
// - No non-maskable request is ever raised.
// - Vectors 4 to 7 are the system sources.
// - Level register holds fields at 2:0, 10:8.
`timescale 1ns/1ps
module pvi_ctrl #(
  parameter int NUM_SRC = 16
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_SRC-1:0] cause,
  input wire logic [NUM_SRC-1:0] periph_clr,
  input wire logic cpu_ack,
  output logic cpu_irq,
  output logic [2:0] cpu_level,
  output logic [4:0] cpu_vector,
  output logic cpu_nmi,
  output logic [23:0] vector_fetch_addr
);

  localparam int NUM_LVL_REG = NUM_SRC / 2;

  // Address match of level register k, shared by the write and read paths
  // so both decode the same word.
  function automatic logic lvl_hit(input logic [7:0] a, input int k);
    lvl_hit = (a == 8'(pvi_pkg::OFF_LEVEL0 + 4 * k));
  endfunction : lvl_hit

  // The vector field is five bits wide and level registers pair sources.
  if (NUM_SRC < 2 || NUM_SRC % 2 != 0 ||
      pvi_pkg::FIRST_VECTOR + NUM_SRC - 1 > pvi_pkg::MAX_VECTOR) begin : g_bad
    $error("pvi_ctrl: NUM_SRC must be even and fit vectors up to 31");
  end

  logic acc_setup;
  logic wr_en;
  logic wr_lo;
  logic wr_hi;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic prot_open_r;
  logic [7:0] base_mid_r;
  logic [7:0] base_top_r;
  logic [23:0] table_base;
  logic [2:0] level_r [NUM_SRC];
  logic [3*NUM_SRC-1:0] levels_flat;
  logic [NUM_SRC-1:0] flags;
  logic [NUM_SRC-1:0] enables;
  logic [NUM_SRC-1:0] requests;
  logic [NUM_SRC-1:0] sw_clr;
  logic en_we;
  logic arb_any;
  logic [2:0] arb_level;
  logic [4:0] arb_vector;
  logic irq_r;
  logic [2:0] level_out_r;
  logic [4:0] vector_out_r;
  logic [23:0] fetch_r;
  logic [4:0] accepted_vec_r;
  logic [2:0] accepted_lvl_r;
  logic accepted_valid_r;

  // APB phases: reads are captured in setup so the data leaves a flop,
  // and writes land at the access edge, the one where pready is seen.
  assign acc_setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign wr_lo = wr_en && pstrb[0];
  assign wr_hi = wr_en && pstrb[1];

  // The slave never stalls; every access completes in its access cycle.
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  // Protection key: the exact key opens, any other full write closes.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      prot_open_r <= 1'b0;
    end else if (wr_lo && wr_hi && paddr == pvi_pkg::OFF_PROT) begin
      prot_open_r <= (pwdata[15:0] == pvi_pkg::PROT_KEY);
    end
  end

  // Middle base byte: writable only while protection is open.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      base_mid_r <= pvi_pkg::BASE_MID_RST;
    end else if (wr_hi && prot_open_r && paddr == pvi_pkg::OFF_BASE_LOW) begin
      base_mid_r <= pwdata[15:8];
    end
  end

  // Top base byte, the same protection applying.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      base_top_r <= pvi_pkg::BASE_TOP_RST;
    end else if (wr_lo && prot_open_r && paddr == pvi_pkg::OFF_BASE_HIGH) begin
      base_top_r <= pwdata[7:0];
    end
  end

  // The low byte has no storage, so the table sits on a 256-byte boundary.
  assign table_base = {base_top_r, base_mid_r, 8'h00};

  // Level registers: each word pairs an even and an odd source.
  // A level change while the source can request takes effect at once;
  // software is expected to keep the source quiet meanwhile.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      for (int s = 0; s < NUM_SRC; s++) begin
        level_r[s] <= 3'h0;
      end
    end else begin
      for (int k = 0; k < NUM_LVL_REG; k++) begin
        if (lvl_hit(paddr, k)) begin
          if (wr_lo) begin
            level_r[2*k] <= pwdata[pvi_pkg::LVL_EVEN_LSB +: 3];
          end
          if (wr_hi) begin
            level_r[2*k+1] <= pwdata[pvi_pkg::LVL_ODD_LSB +: 3];
          end
        end
      end
    end
  end

  // Flatten the levels for the arbiter.
  always_comb begin
    levels_flat = '0;
    for (int s = 0; s < NUM_SRC; s++) begin
      levels_flat[3*s +: 3] = level_r[s];
    end
  end

  // Software clears flags by writing ones; enables are written whole.
  assign en_we = wr_lo && wr_hi && paddr == pvi_pkg::OFF_ENABLE;
  always_comb begin
    sw_clr = '0;
    if (wr_lo && wr_hi && paddr == pvi_pkg::OFF_FLAGS) begin
      sw_clr = pwdata[NUM_SRC-1:0];
    end
  end

  // One flag and enable pair per source; source 0 is vector 4.
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
    pvi_source_cell u_cell (
      .core_clk(core_clk),
      .resetn(resetn),
      .cause(cause[g]),
      .periph_clr(periph_clr[g]),
      .sw_clr(sw_clr[g]),
      .en_we(en_we),
      .en_wdata(pwdata[g]),
      .flag(flags[g]),
      .enable(enables[g]),
      .request(requests[g])
    );
  end

  // Vectors 4 to 7 are the system sources, the timer starts at 8.
  pvi_interrupt_arbiter #(
    .NUM_SRC(NUM_SRC),
    .FIRST_VEC(pvi_pkg::FIRST_VECTOR)
  ) u_arb (
    .req(requests),
    .levels(levels_flat),
    .any_req(arb_any),
    .win_level(arb_level),
    .win_vector(arb_vector)
  );

  // Outputs to the CPU are re-registered every cycle from the live
  // requests. A withdrawn flag drops out one cycle later, and a higher
  // newcomer replaces the presented pair while losers stay requested.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irq_r <= 1'b0;
      level_out_r <= 3'h0;
      vector_out_r <= 5'h00;
    end else begin
      irq_r <= arb_any;
      level_out_r <= arb_level;
      vector_out_r <= arb_vector;
    end
  end

  // Fetch address tracks the presented vector through the base.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      fetch_r <= 24'h000000;
    end else begin
      fetch_r <= pvi_pkg::vec_fetch_addr(table_base, arb_vector);
    end
  end

  assign cpu_irq = irq_r;
  assign cpu_level = level_out_r;
  assign cpu_vector = vector_out_r;
  assign vector_fetch_addr = fetch_r;

  // This controller has no non-maskable source at all.
  assign cpu_nmi = 1'b0;

  // Record what the CPU last accepted, for software to inspect. The
  // controller does not clear flags on acceptance: the peripheral does,
  // so a source stays requested until its own clear arrives.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      accepted_vec_r <= 5'h00;
      accepted_lvl_r <= 3'h0;
      accepted_valid_r <= 1'b0;
    end else if (cpu_ack && irq_r) begin
      accepted_vec_r <= vector_out_r;
      accepted_lvl_r <= level_out_r;
      accepted_valid_r <= 1'b1;
    end
  end

  // Read decode; unmapped addresses read zero and answer with an error.
  always_comb begin
    rd_data = 32'h00000000;
    rd_hit = 1'b1;
    unique case (paddr)
      pvi_pkg::OFF_PROT: rd_data[0] = prot_open_r;
      pvi_pkg::OFF_BASE_LOW: rd_data[15:0] = table_base[15:0];
      pvi_pkg::OFF_BASE_HIGH: rd_data[7:0] = table_base[23:16];
      pvi_pkg::OFF_FLAGS: rd_data[NUM_SRC-1:0] = flags;
      pvi_pkg::OFF_ENABLE: rd_data[NUM_SRC-1:0] = enables;
      pvi_pkg::OFF_STATUS: begin
        rd_data[pvi_pkg::STAT_IRQ_BIT] = irq_r;
        rd_data[pvi_pkg::STAT_LVL_LSB +: 3] = level_out_r;
        rd_data[pvi_pkg::STAT_VEC_LSB +: 5] = vector_out_r;
      end
      pvi_pkg::OFF_ACCEPTED: begin
        rd_data[pvi_pkg::STAT_IRQ_BIT] = accepted_valid_r;
        rd_data[pvi_pkg::STAT_LVL_LSB +: 3] = accepted_lvl_r;
        rd_data[pvi_pkg::STAT_VEC_LSB +: 5] = accepted_vec_r;
      end
      default: begin
        rd_hit = 1'b0;
        for (int k = 0; k < NUM_LVL_REG; k++) begin
          if (lvl_hit(paddr, k)) begin
            rd_hit = 1'b1;
            rd_data[pvi_pkg::LVL_EVEN_LSB +: 3] = level_r[2*k];
            rd_data[pvi_pkg::LVL_ODD_LSB +: 3] = level_r[2*k+1];
          end
        end
      end
    endcase
  end

  // Read data and error are captured in the setup cycle and held through
  // the access cycle, so the master sees flop outputs at its sample edge.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (acc_setup) begin
      prdata_r <= pwrite ? 32'h00000000 : rd_data;
      pslverr_r <= !rd_hit;
    end
  end

endmodule : pvi_ctrl

// ==== test/pvi_ctrl_chk.sv ====
// Checker of the controller's pins, bound to every pvi_ctrl instance.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module pvi_ctrl_chk #(
  parameter int NUM_SRC = 16
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [NUM_SRC-1:0] cause,
  input wire logic [NUM_SRC-1:0] periph_clr,
  input wire logic cpu_irq,
  input wire logic [4:0] cpu_vector,
  input wire logic cpu_nmi,
  input wire logic [23:0] vector_fetch_addr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Table base implied by the fetch address; only bus writes may move it.
  logic [23:0] base_est;
  logic wr_acc;
  assign base_est = vector_fetch_addr - {17'h00000, cpu_vector, 2'b00};
  assign wr_acc = psel && penable && pwrite;
  // Full clear with no new cause over two edges empties every flag.
  sequence s_clear_all;
    (&periph_clr && cause == '0) ##1 (cause == '0);
  endsequence
  a_nmi_idle: assert property (cpu_nmi == 1'b0)
    else $error("nmi line raised");
  a_fetch_low: assert property (
    vector_fetch_addr[7:0] == {1'b0, cpu_vector, 2'b00})
    else $error("fetch address low byte wrong");
  a_idle_vector: assert property (
    !cpu_irq |-> cpu_vector == 5'h00)
    else $error("vector shown without request");
  a_vector_range: assert property (
    cpu_irq |-> cpu_vector inside {[5'h04:5'h13]})
    else $error("vector outside source range");
  a_base_reset: assert property (
    $rose(resetn) |=> base_est == 24'h008000)
    else $error("table base wrong after reset");
  a_quiet_start: assert property (
    $rose(resetn) |-> !cpu_irq [*3])
    else $error("request right after reset");
  a_base_steady: assert property (
    ($past(resetn) && $past(resetn, 2) && !$past(wr_acc) &&
     !$past(wr_acc, 2)) |-> $stable(base_est))
    else $error("table base moved without a write");
  a_clear_withdraw: assert property (s_clear_all |=> !cpu_irq)
    else $error("request kept after flags cleared");
endmodule : pvi_ctrl_chk

bind pvi_ctrl pvi_ctrl_chk #(.NUM_SRC(NUM_SRC)) u_pvi_ctrl_chk (
  .core_clk, .resetn, .psel, .penable, .pwrite, .cause, .periph_clr,
  .cpu_irq, .cpu_vector, .cpu_nmi, .vector_fetch_addr);

// ==== test/pvi_cpu_model.sv ====
// Behavioural CPU core that accepts or refuses presented requests.
// Assumes the bench pulses ie_set where software would enable interrupts.
`timescale 1ns/1ps
module pvi_cpu_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cpu_irq,
  input wire logic [2:0] cpu_level,
  input wire logic [4:0] cpu_vector,
  input wire logic ie_set,
  input wire logic [2:0] cur_level,
  input wire logic stall,
  output logic cpu_ack,
  output logic [4:0] acc_vector
);
  logic ie_r;
  logic take;
  // Level 0 never exceeds the current level, so it is always refused.
  assign take = cpu_irq && ie_r && !stall &&
                (cpu_level > cur_level);
  // Acceptance clears the enable, so at most one ack follows each ie_set pulse.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ie_r <= 1'b0;
      cpu_ack <= 1'b0;
      acc_vector <= 5'h00;
    end else begin
      cpu_ack <= take;
      ie_r <= take ? 1'b0 : (ie_set ? 1'b1 : ie_r);
      acc_vector <= take ? cpu_vector : acc_vector;
    end
  end
endmodule : pvi_cpu_model

// ==== test/tb_pvi_ctrl.sv ====
// Self-checking bench for the prioritized vector interrupt controller.
// Assumes zero-wait APB answers and a behavioural CPU on the far side.
`timescale 1ns/1ps
module tb_pvi_ctrl;
  logic core_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [15:0] cause, periph_clr, en;
  logic cpu_ack, cpu_irq, cpu_nmi, ie_set, stall;
  logic [2:0] cpu_level, cur_level;
  logic [4:0] cpu_vector, acc_vector;
  logic [23:0] vector_fetch_addr, base;
  int miscompares, cmp_count;
  // Ordinary cases: source, its level, and the vector it must present.
  logic [3:0] row_src [4] = '{4'h0, 4'h4, 4'h7, 4'hf};
  logic [2:0] row_lvl [4] = '{3'h7, 3'h1, 3'h5, 3'h3};
  logic [4:0] row_vec [4] = '{5'h04, 5'h08, 5'h0b, 5'h13};
  pvi_ctrl u_pvi_ctrl (.core_clk, .resetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .cause,
    .periph_clr, .cpu_ack, .cpu_irq, .cpu_level, .cpu_vector, .cpu_nmi,
    .vector_fetch_addr);
  pvi_cpu_model u_pvi_cpu_model (.core_clk, .resetn, .cpu_irq, .cpu_level,
    .cpu_vector, .ie_set, .cur_level, .stall, .cpu_ack, .acc_vector);
  // Free-running 100 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Both strobes last one edge; outputs are looked at one edge later.
  task automatic pulse(input logic [15:0] c, p);
    @(posedge core_clk);
    cause <= c;
    periph_clr <= p;
    @(posedge core_clk);
    cause <= 16'h0000;
    periph_clr <= 16'h0000;
    @(posedge core_clk);
    #1;
  endtask : pulse
  task automatic setlvl(input logic [3:0] s, input logic [2:0] l);
    apb(1'b1, pvi_pkg::OFF_LEVEL0 + {3'h0, s[3:1], 2'b00},
        s[0] ? {21'h0, l, 8'h00} : {29'h0, l}, s[0] ? 4'h2 : 4'h1);
  endtask : setlvl
  task automatic see(input logic i, input logic [2:0] l,
                     input logic [4:0] v);
    chk("irq", {31'h0, cpu_irq}, {31'h0, i});
    chk("nmi", {31'h0, cpu_nmi}, 32'h0);
    if (i) begin
      chk("level", {29'h0, cpu_level}, {29'h0, l});
      chk("vector", {27'h0, cpu_vector}, {27'h0, v});
      chk("fetch", {8'h0, vector_fetch_addr},
          {8'h0, base + {17'h0, v, 2'b00}});
    end
  endtask : see
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    summarize();
  end
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {cause, periph_clr, ie_set, stall, cur_level, en} = '0;
    {miscompares, cmp_count} = '0;
    base = 24'h008000;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    apb(1'b0, pvi_pkg::OFF_BASE_LOW, 32'h0, 4'h0);
    chk("base_low", rd, 32'h00008000);
    apb(1'b0, pvi_pkg::OFF_LEVEL0 + 8'h1c, 32'h0, 4'h0);
    chk("level_rst", rd, 32'h0);
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      setlvl(row_src[k], row_lvl[k]);
      en = 16'h0001 << row_src[k];
      apb(1'b1, pvi_pkg::OFF_ENABLE, {16'h0, en}, 4'h3);
      pulse(en, 16'h0000);
      see(1'b1, row_lvl[k], row_vec[k]);
      apb(1'b1, pvi_pkg::OFF_FLAGS, {16'h0, en}, 4'h3);
      pulse(16'h0000, 16'h0000);
      see(1'b0, 3'h0, 5'h00);
    end
    $display("table test done");
    apb(1'b1, pvi_pkg::OFF_BASE_LOW, 32'h1200, 4'h3);
    apb(1'b1, pvi_pkg::OFF_PROT, {16'h0, pvi_pkg::PROT_KEY}, 4'h3);
    apb(1'b1, pvi_pkg::OFF_BASE_LOW, 32'h34ff, 4'h3);
    apb(1'b1, pvi_pkg::OFF_BASE_HIGH, 32'h0005, 4'h3);
    apb(1'b1, pvi_pkg::OFF_PROT, 32'h0, 4'h3);
    apb(1'b1, pvi_pkg::OFF_BASE_LOW, 32'h5600, 4'h3);
    apb(1'b0, pvi_pkg::OFF_BASE_LOW, 32'h0, 4'h0);
    chk("base_low", rd, 32'h00003400);
    apb(1'b0, 8'hfc, 32'h0, 4'h0);
    chk("slverr", {31'h0, pslverr}, 32'h1);
    base = 24'h053400;
    $display("protection test done");
    setlvl(4'h1, 3'h3);
    setlvl(4'h3, 3'h3);
    setlvl(4'h6, 3'h6);
    setlvl(4'h2, 3'h2);
    en = 16'h004a;
    apb(1'b1, pvi_pkg::OFF_ENABLE, {16'h0, en}, 4'h3);
    pulse(16'h000e, 16'h0000);
    see(1'b1, 3'h3, 5'h05);
    apb(1'b0, pvi_pkg::OFF_STATUS, 32'h0, 4'h0);
    chk("status", rd & 32'h0000ffff, 32'h00008305);
    pulse(16'h0040, 16'h0000);
    see(1'b1, 3'h6, 5'h0a);
    apb(1'b1, pvi_pkg::OFF_FLAGS, 32'h0040, 4'h3);
    pulse(16'h0000, 16'h0000);
    see(1'b1, 3'h3, 5'h05);
    @(posedge core_clk);
    stall <= 1'b1;
    ie_set <= 1'b1;
    @(posedge core_clk);
    ie_set <= 1'b0;
    repeat (3) @(posedge core_clk);
    stall <= 1'b0;
    // The CPU answers one edge after the stall drops and the record
    // lands one edge later, so both must pass before the read setup.
    repeat (2) @(posedge core_clk);
    apb(1'b0, pvi_pkg::OFF_ACCEPTED, 32'h0, 4'h0);
    chk("accepted", rd & 32'h0000ffff, 32'h00008305);
    chk("acc_vector", {27'h0, acc_vector}, 32'h00000005);
    pulse(16'h0000, 16'h0002);
    see(1'b1, 3'h3, 5'h07);
    en = 16'h004e;
    apb(1'b1, pvi_pkg::OFF_ENABLE, {16'h0, en}, 4'h3);
    pulse(16'h0000, 16'h0008);
    see(1'b1, 3'h2, 5'h06);
    pulse(16'h0000, 16'hffff);
    see(1'b0, 3'h0, 5'h00);
    $display("priority test done");
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    apb(1'b0, pvi_pkg::OFF_BASE_LOW, 32'h0, 4'h0);
    chk("base_again", rd, 32'h00008000);
    $display("second reset test done");
    summarize();
  end
endmodule : tb_pvi_ctrl
